// ### core/tci_pkg.sv
/*
 Shared constants, carriers and state codes for the touch controller two-wire target port.
 Assumes one 20 MHz clock and a host that drives SCL and owns the bus.
*/
// Function
// [R1] Host starts every transfer; target only answers
// [R2] Host keeps bit rate at most 400 kbit/s
// [R3] Answer only the strap-selected address pair
// [R4] Host selects pair via reset/interrupt pin strap
// [R5] SDA falling while SCL high is start
// [R6] Matching address acknowledged low on ninth clock
// [R7] Mismatched address: no acknowledge, idle until start
// [R8] Byte is eight bits plus acknowledge slot
// [R9] Sample while SCL high, change while low
// [R10] SDA rising while SCL high ends transfer
// [R11] Write: address, pointer high, low, then data
// [R12] Pointer increments after each written data byte
// [R13] Host ends write burst with stop
// [R14] Read: set pointer, repeated start, read address
// [R15] Host acknowledges bytes, last gets NACK, stop
// [R16] Pointer advances per sent byte; NACK releases
// [R17] Drive SDA low only in ack/read bits
package tci_pkg;

    // Bus figures for timing math
    localparam int          CLK_HZ      = 20_000_000;
    localparam int          BUS_BPS_MAX = 400_000;

    // Address bytes with direction bit included
    localparam logic [7:0]  ADDR_WR_A   = 8'hBA;
    localparam logic [7:0]  ADDR_RD_A   = 8'hBB;
    localparam logic [7:0]  ADDR_WR_B   = 8'h28;
    localparam logic [7:0]  ADDR_RD_B   = 8'h29;

    // Bit counting within one byte frame
    localparam logic [3:0]  BIT_ZERO    = 4'h0;
    localparam logic [3:0]  BIT_STEP    = 4'h1;
    localparam logic [3:0]  BIT_LAST_RX = 4'h8;
    localparam logic [3:0]  BIT_LAST_TX = 4'h7;

    // Pointer reset and stride
    localparam logic [15:0] PTR_RST     = 16'h0000;
    localparam logic [15:0] PTR_STEP    = 16'h0001;

    // Strap capture runs past the filter delay, else a reset value is taken
    localparam logic [2:0]  STRAP_ZERO  = 3'h0;
    localparam logic [2:0]  STRAP_STEP  = 3'h1;
    localparam logic [2:0]  STRAP_WAIT  = 3'h5;

    // Write stream buffer shape
    localparam int          FIFO_DEPTH  = 8;
    localparam int          WORD_W      = 24;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
    } tci_wr_word_type;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_RX     = 6'h02,
        ST_RX_ACK = 6'h04,
        ST_TX     = 6'h08,
        ST_TX_ACK = 6'h10,
        ST_WAIT   = 6'h20
    } tci_state_type;

    typedef enum logic [3:0] {
        K_ADDR   = 4'h1,
        K_PTR_HI = 4'h2,
        K_PTR_LO = 4'h4,
        K_DATA   = 4'h8
    } tci_kind_type;

endpackage

// ### core/tci_sync.sv
/*
 Three-stage pin synchroniser with an agreement filter.
 Assumes the input is asynchronous to ref_clk_i; output changes only when stages two and three agree.
*/
`timescale 1ns/1ps
module tci_sync #(
    parameter logic INIT = 1'b1
) (
    input  wire logic ref_clk_i,
    input  wire logic srst_i,
    input  wire logic pin_i,
    output wire logic level_o
);
    logic s1_r, s2_r, s3_r, filt_r;
    logic filt_nxt;

    // Filter only looks at the later stages; stage one feeds stage two alone
    always_comb
    begin
        filt_nxt = (s2_r == s3_r) ? s3_r : filt_r;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            s1_r   <= INIT;
            s2_r   <= INIT;
            s3_r   <= INIT;
            filt_r <= INIT;
        end
        else
        begin
            s1_r   <= pin_i;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            filt_r <= filt_nxt;
        end
    end

    assign level_o = filt_r;
endmodule // tci_sync

// ### core/tci_fifo.sv
/*
 Flip-flop FIFO with valid/ready on both sides.
 Assumes a single clock; full and empty follow the stored count exactly.
*/
`timescale 1ns/1ps
module tci_fifo #(
    parameter int WIDTH = tci_pkg::WORD_W,
    parameter int DEPTH = tci_pkg::FIFO_DEPTH
) (
    input  wire logic             ref_clk_i,
    input  wire logic             srst_i,
    input  wire logic             in_valid_i,
    output wire logic             in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output wire logic             out_valid_o,
    input  wire logic             out_ready_i,
    output wire logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]      cnt_r, cnt_nxt;
    logic             do_push, do_pop;

    // Pointer and count update; push and pop may coincide
    always_comb
    begin
        do_push = in_valid_i && in_ready_o;
        do_pop  = out_valid_o && out_ready_i;
        wp_nxt  = wp_r;
        rp_nxt  = rp_r;
        cnt_nxt = cnt_r;
        if (do_push)
        begin
            wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
        end
        if (do_pop)
        begin
            rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
        end
        if (do_push && !do_pop)
        begin
            cnt_nxt = cnt_r + (AW+1)'(1);
        end
        else if (do_pop && !do_push)
        begin
            cnt_nxt = cnt_r - (AW+1)'(1);
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end
        else
        begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage needs no reset; reads are gated by valid
    always_ff @(posedge ref_clk_i)
    begin
        if (do_push)
        begin
            mem_r[wp_r] <= in_data_i;
        end
    end

    assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o  = mem_r[rp_r];
endmodule // tci_fifo

// ### core/tci_target.sv
/*
 Two-wire serial target port: start/stop detection, address match, pointer, write stream, reads.
 Assumes the host drives SCL slowly against ref_clk_i (at most 400 kbit/s, 50 edges per bit at 20 MHz),
 the wire level is resolved outside from sda_oe_o, and rd_data_i follows rd_addr_o combinationally.
*/
`timescale 1ns/1ps
module tci_target (
    input  wire logic                     ref_clk_i,
    input  wire logic                     srst_i,
    input  wire logic                     scl_i,
    input  wire logic                     sda_i,
    output wire logic                     sda_o,
    output wire logic                     sda_oe_o,
    input  wire logic                     addr_alt_i,
    output wire logic                     wr_valid_o,
    input  wire logic                     wr_ready_i,
    output wire tci_pkg::tci_wr_word_type wr_word_o,
    output wire logic [15:0]              rd_addr_o,
    input  wire logic [7:0]               rd_data_i,
    output wire logic                     rd_strobe_o,
    output wire logic                     busy_o
);
    ////////////////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic scl_f, sda_f, alt_f;

    tci_sync #(.INIT(1'b1)) u_sync_scl (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .pin_i     (scl_i),
        .level_o   (scl_f)
    );
    tci_sync #(.INIT(1'b1)) u_sync_sda (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .pin_i     (sda_i),
        .level_o   (sda_f)
    );
    tci_sync #(.INIT(1'b0)) u_sync_alt (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .pin_i     (addr_alt_i),
        .level_o   (alt_f)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Edge history and strap capture
    logic       scl_d_r, scl_d_nxt, sda_d_r, sda_d_nxt;
    logic [2:0] strap_cnt_r, strap_cnt_nxt;
    logic       addr_alt_r, addr_alt_nxt;
    logic       scl_rise, scl_fall, start_evt, stop_evt;

    // Strap follows the synchroniser for five cycles after release, then holds the settled value
    always_comb
    begin
        scl_d_nxt     = scl_f;
        sda_d_nxt     = sda_f;
        strap_cnt_nxt = strap_cnt_r;
        addr_alt_nxt  = addr_alt_r;
        if (strap_cnt_r != tci_pkg::STRAP_WAIT)
        begin
            strap_cnt_nxt = strap_cnt_r + tci_pkg::STRAP_STEP;
            addr_alt_nxt  = alt_f; // R4
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            scl_d_r     <= 1'b1;
            sda_d_r     <= 1'b1;
            strap_cnt_r <= tci_pkg::STRAP_ZERO;
            addr_alt_r  <= 1'b0;
        end
        else
        begin
            scl_d_r     <= scl_d_nxt;
            sda_d_r     <= sda_d_nxt;
            strap_cnt_r <= strap_cnt_nxt;
            addr_alt_r  <= addr_alt_nxt;
        end
    end

    // Bus conditions on filtered levels
    assign scl_rise  = scl_f && !scl_d_r;
    assign scl_fall  = !scl_f && scl_d_r;
    assign start_evt = scl_f && scl_d_r && sda_d_r && !sda_f;  // R5
    assign stop_evt  = scl_f && scl_d_r && !sda_d_r && sda_f;  // R10

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Protocol engine
    tci_pkg::tci_state_type state_r, state_nxt;
    tci_pkg::tci_kind_type  kind_r, kind_nxt;
    logic [3:0]             bit_r, bit_nxt;
    logic [7:0]             shreg_r, shreg_nxt;
    logic [15:0]            ptr_r, ptr_nxt;
    logic                   rw_r, rw_nxt;
    logic                   oe_r, oe_nxt;
    logic                   nack_r, nack_nxt;
    logic                   take_r, take_nxt;
    logic                   push, fifo_ready, addr_hit;
    logic [7:0]             sel_wr, sel_rd;

    assign sel_wr   = addr_alt_r ? tci_pkg::ADDR_WR_B : tci_pkg::ADDR_WR_A;
    assign sel_rd   = addr_alt_r ? tci_pkg::ADDR_RD_B : tci_pkg::ADDR_RD_A;
    assign addr_hit = (shreg_r == sel_wr) || (shreg_r == sel_rd); // R3

    // Next state; stop beats start beats byte progress
    always_comb
    begin
        state_nxt = state_r;
        kind_nxt  = kind_r;
        bit_nxt   = bit_r;
        shreg_nxt = shreg_r;
        ptr_nxt   = ptr_r;
        rw_nxt    = rw_r;
        oe_nxt    = oe_r;
        nack_nxt  = nack_r;
        take_nxt  = 1'b0;
        push      = 1'b0;
        if (stop_evt)
        begin
            state_nxt = tci_pkg::ST_IDLE; // R10
            oe_nxt    = 1'b0;
        end
        else if (start_evt)
        begin
            state_nxt = tci_pkg::ST_RX; // R5
            kind_nxt  = tci_pkg::K_ADDR;
            bit_nxt   = tci_pkg::BIT_ZERO;
            oe_nxt    = 1'b0;
        end
        else
        begin
            unique case (state_r)
                tci_pkg::ST_IDLE, tci_pkg::ST_WAIT:
                begin
                    oe_nxt = 1'b0; // R7
                end
                tci_pkg::ST_RX:
                begin
                    if (scl_rise)
                    begin
                        shreg_nxt = {shreg_r[6:0], sda_f}; // R9
                        bit_nxt   = bit_r + tci_pkg::BIT_STEP; // R8
                    end
                    else if (scl_fall && bit_r == tci_pkg::BIT_LAST_RX)
                    begin
                        state_nxt = tci_pkg::ST_RX_ACK;
                        bit_nxt   = tci_pkg::BIT_ZERO;
                        oe_nxt    = 1'b1; // R6
                        unique case (kind_r)
                            tci_pkg::K_ADDR:
                            begin
                                rw_nxt = shreg_r[0];
                                if (!addr_hit)
                                begin
                                    state_nxt = tci_pkg::ST_WAIT; // R7
                                    oe_nxt    = 1'b0;
                                end
                            end
                            tci_pkg::K_PTR_HI: ptr_nxt = {shreg_r, ptr_r[7:0]};
                            tci_pkg::K_PTR_LO: ptr_nxt = {ptr_r[15:8], shreg_r};
                            tci_pkg::K_DATA:
                            begin
                                // Full buffer answers NACK rather than stretching SCL
                                if (fifo_ready)
                                begin
                                    push    = 1'b1;
                                    ptr_nxt = ptr_r + tci_pkg::PTR_STEP; // R12
                                end
                                else
                                begin
                                    state_nxt = tci_pkg::ST_WAIT;
                                    oe_nxt    = 1'b0;
                                end
                            end
                        endcase
                    end
                end
                tci_pkg::ST_RX_ACK:
                begin
                    if (scl_fall)
                    begin
                        oe_nxt = 1'b0; // R17
                        if (kind_r == tci_pkg::K_ADDR && rw_r)
                        begin
                            state_nxt = tci_pkg::ST_TX; // R15
                            shreg_nxt = rd_data_i;
                            take_nxt  = 1'b1;
                            oe_nxt    = !rd_data_i[7]; // R17
                        end
                        else
                        begin
                            state_nxt = tci_pkg::ST_RX;
                            kind_nxt  = (kind_r == tci_pkg::K_ADDR)   ? tci_pkg::K_PTR_HI :
                                        (kind_r == tci_pkg::K_PTR_HI) ? tci_pkg::K_PTR_LO :
                                                                         tci_pkg::K_DATA;
                        end
                    end
                end
                tci_pkg::ST_TX:
                begin
                    // Data moves only on the falling edge, so SCL is low
                    if (scl_fall)
                    begin
                        if (bit_r == tci_pkg::BIT_LAST_TX)
                        begin
                            state_nxt = tci_pkg::ST_TX_ACK;
                            oe_nxt    = 1'b0;
                            ptr_nxt   = ptr_r + tci_pkg::PTR_STEP; // R16
                        end
                        else
                        begin
                            shreg_nxt = {shreg_r[6:0], 1'b0};
                            bit_nxt   = bit_r + tci_pkg::BIT_STEP; // R8
                            oe_nxt    = !shreg_r[6]; // R9
                        end
                    end
                end
                tci_pkg::ST_TX_ACK:
                begin
                    if (scl_rise)
                    begin
                        nack_nxt = sda_f; // R15
                    end
                    else if (scl_fall)
                    begin
                        bit_nxt = tci_pkg::BIT_ZERO;
                        if (nack_r)
                        begin
                            state_nxt = tci_pkg::ST_WAIT; // R16
                        end
                        else
                        begin
                            state_nxt = tci_pkg::ST_TX;
                            shreg_nxt = rd_data_i;
                            take_nxt  = 1'b1;
                            oe_nxt    = !rd_data_i[7];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            state_r <= tci_pkg::ST_IDLE;
            kind_r  <= tci_pkg::K_ADDR;
            bit_r   <= tci_pkg::BIT_ZERO;
            shreg_r <= 8'h00;
            ptr_r   <= tci_pkg::PTR_RST;
            rw_r    <= 1'b0;
            oe_r    <= 1'b0;
            nack_r  <= 1'b0;
            take_r  <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            kind_r  <= kind_nxt;
            bit_r   <= bit_nxt;
            shreg_r <= shreg_nxt;
            ptr_r   <= ptr_nxt;
            rw_r    <= rw_nxt;
            oe_r    <= oe_nxt;
            nack_r  <= nack_nxt;
            take_r  <= take_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Write stream buffer
    tci_pkg::tci_wr_word_type push_word;
    assign push_word = '{addr: ptr_r, data: shreg_r};

    tci_fifo #(.WIDTH(tci_pkg::WORD_W), .DEPTH(tci_pkg::FIFO_DEPTH)) u_wr_fifo (
        .ref_clk_i   (ref_clk_i),
        .srst_i      (srst_i),
        .in_valid_i  (push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (push_word),
        .out_valid_o (wr_valid_o),
        .out_ready_i (wr_ready_i),
        .out_data_o  (wr_word_o)
    );

    // Open drain: the driven level is always low
    assign sda_o       = 1'b0; // R17
    assign sda_oe_o    = oe_r;
    assign rd_addr_o   = ptr_r;
    assign rd_strobe_o = take_r;
    assign busy_o      = (state_r != tci_pkg::ST_IDLE);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    a_oe_legal_slot: assert property (oe_r |-> state_r inside {tci_pkg::ST_RX_ACK, // R17
        tci_pkg::ST_TX}) else $error("SDA driven outside ack or read bit");
    a_start_to_addr: assert property (start_evt && !stop_evt |=> state_r == tci_pkg::ST_RX // R5
        && kind_r == tci_pkg::K_ADDR && bit_r == tci_pkg::BIT_ZERO)
        else $error("Start not followed by address capture");
    a_stop_to_idle: assert property (stop_evt |=> state_r == tci_pkg::ST_IDLE && !oe_r) // R10
        else $error("Stop did not return to idle");
    a_ack_selected: assert property (state_r == tci_pkg::ST_RX_ACK && oe_r // R3
        && kind_r == tci_pkg::K_ADDR |-> shreg_r[7:1] == sel_wr[7:1])
        else $error("Acknowledged an address outside the selected pair");
    a_ack_on_match: assert property (state_r == tci_pkg::ST_RX && kind_r == tci_pkg::K_ADDR // R6
        && scl_fall && bit_r == tci_pkg::BIT_LAST_RX && addr_hit && !start_evt && !stop_evt
        |=> oe_r && state_r == tci_pkg::ST_RX_ACK)
        else $error("Matching address not acknowledged");
    a_nack_mismatch: assert property (state_r == tci_pkg::ST_RX && kind_r == tci_pkg::K_ADDR // R7
        && scl_fall && bit_r == tci_pkg::BIT_LAST_RX && !addr_hit && !start_evt && !stop_evt
        |=> state_r == tci_pkg::ST_WAIT ##1 !oe_r)
        else $error("Mismatched address not ignored");
    a_byte_bits: assert property (state_r == tci_pkg::ST_RX // R8
        |-> bit_r <= tci_pkg::BIT_LAST_RX) else $error("Receive bit count past eight");
    a_sample_high: assert property (state_r == tci_pkg::ST_RX && !scl_rise // R9
        |=> $stable(shreg_r)) else $error("Receive shift outside SCL rise");
    a_oe_scl_low: assert property ($changed(oe_r) && !$past(stop_evt) && !$past(start_evt) // R9
        |-> !scl_f) else $error("SDA drive changed while SCL high");
    a_ptr_write: assert property (push |=> ptr_r == $past(ptr_r) + tci_pkg::PTR_STEP) // R12
        else $error("Pointer not advanced after write");
    a_ptr_read: assert property (state_r == tci_pkg::ST_TX && scl_fall && !start_evt // R16
        && !stop_evt && bit_r == tci_pkg::BIT_LAST_TX
        |=> ptr_r == $past(ptr_r) + tci_pkg::PTR_STEP)
        else $error("Pointer not advanced after sent byte");
    a_nack_release: assert property (state_r == tci_pkg::ST_TX_ACK && scl_fall && nack_r // R15
        && !start_evt && !stop_evt |=> (state_r == tci_pkg::ST_WAIT && !oe_r) [*2])
        else $error("Data driven after host NACK");

    c_write_data: cover property (push);
    c_read_nack: cover property (state_r == tci_pkg::ST_TX_ACK && scl_fall && nack_r);
    c_addr_miss: cover property (state_r == tci_pkg::ST_RX && kind_r == tci_pkg::K_ADDR
        && scl_fall && bit_r == tci_pkg::BIT_LAST_RX && !addr_hit);
    c_full_nack: cover property (state_r == tci_pkg::ST_RX && kind_r == tci_pkg::K_DATA
        && scl_fall && bit_r == tci_pkg::BIT_LAST_RX && !fifo_ready);
endmodule // tci_target

// ### dv/tci_host_model.sv
/*
 Host-side model of the two-wire bus: start, stop, byte write and byte read.
 Assumes the bench resolves the open-drain data wire and feeds it to sda_i.
*/
`timescale 1ns/1ps
module tci_host_model #(
    parameter int HALF = 25
) (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output var  logic scl_o,
    output var  logic sda_low_o
);
    ////////////////////////////////////////////////////////////
    // Idle bus, both lines released to the pull-up
    initial
    begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    // Half bit of 25 clocks, plus 6 after the fall, keeps the rate under 400 kbit/s
    task automatic half();
        repeat (HALF) @(negedge clk_i);
    endtask

    // Serves from idle and as repeated start
    task automatic start();
        sda_low_o = 1'b0;
        half();
        scl_o = 1'b1;
        half();
        sda_low_o = 1'b1;
        half();
        scl_o = 1'b0;
        half();
    endtask

    // Data moves only with SCL low, and well after the fall
    task automatic bit_io(input logic b, output logic r);
        sda_low_o = ~b;
        half();
        scl_o = 1'b1;
        half();
        r     = sda_i;
        scl_o = 1'b0;
        repeat (6) @(negedge clk_i);
    endtask

    task automatic stop();
        sda_low_o = 1'b1;
        half();
        scl_o = 1'b1;
        half();
        sda_low_o = 1'b0;
        half();
    endtask

    // Eight bits MSB first, then the target's answer
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    // Last byte of a read answered with a NACK
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, d[i]);
        end
        bit_io(last, r);
    endtask
endmodule // tci_host_model

// ### dv/touch_ctrl_i2c_target_port_tb_top.sv
/*
 Self-checking bench: host model, read memory, write consumer with stalls.
 Assumes the design package and modules are compiled before this file.
*/
`timescale 1ns/1ps
module touch_ctrl_i2c_target_port_tb_top;
    logic                     clk, srst, alt, hold, wr_ready, scl, host_low;
    logic                     sda_oe, sda_out, wr_valid, rd_strobe, busy;
    logic [15:0]              rd_addr;
    logic [7:0]               mem [16];
    logic [23:0]              exp_q [$];
    tci_pkg::tci_wr_word_type wr_word;
    wire                      sda = ~(host_low | (sda_oe & ~sda_out));
    int                       error_cnt, total_checks, cyc, stb_cnt;

    ////////////////////////////////////////////////////////////
    tci_target u_dut (.ref_clk_i(clk), .srst_i(srst), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_out), .sda_oe_o(sda_oe), .addr_alt_i(alt), .wr_valid_o(wr_valid),
        .wr_ready_i(wr_ready), .wr_word_o(wr_word), .rd_addr_o(rd_addr),
        .rd_data_i(mem[rd_addr[3:0]]), .rd_strobe_o(rd_strobe), .busy_o(busy));
    tci_host_model u_host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Consumer stalls at random, or fully while the buffer is filled
    always @(negedge clk)
    begin
        wr_ready <= hold ? 1'b0 : 1'($urandom % 2);
    end

    // Popped words against the model queue; cycle ceiling
    always @(posedge clk)
    begin
        cyc++;
        if (!srst && rd_strobe)
            stb_cnt++;
        if (!srst && wr_valid && wr_ready)
            chk24("wr_word", exp_q.pop_front(), wr_word);
        if (cyc == 60000)
        begin
            error_cnt++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic chk1(string n, logic e, logic g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic chk24(string n, logic [23:0] e, logic [23:0] g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Strap stays put from reset until well after release
    task automatic do_reset(logic a);
        srst = 1'b1;
        alt  = a;
        repeat (20) @(negedge clk);
        srst = 1'b0;
        repeat (10) @(negedge clk);
        chk24("ptr_rst", 24'h00_0000, {8'h00, rd_addr});
    endtask

    // Pointer bytes, then n data bytes of which n_ok fit the buffer
    task automatic wr_burst(logic [7:0] wa, logic [15:0] p, int n, int n_ok, logic fin);
        logic       a;
        logic [7:0] d;
        u_host.start();
        u_host.wr_byte(wa, a);
        chk1("addr_ack", 1'b1, a);
        u_host.wr_byte(p[15:8], a);
        u_host.wr_byte(p[7:0], a);
        for (int i = 0; i < n; i++)
        begin
            d = 8'($urandom);
            if (i < n_ok)
                exp_q.push_back({p + 16'(i), d});
            u_host.wr_byte(d, a);
            chk1("data_ack", 1'(i < n_ok), a);
        end
        if (fin)
            u_host.stop();
    endtask

    task automatic rd_burst(logic [7:0] wa, logic [15:0] p, int n);
        logic       a;
        logic [7:0] d;
        wr_burst(wa, p, 0, 0, 1'b0);
        stb_cnt = 0;
        u_host.start();
        u_host.wr_byte(wa | 8'h01, a);
        chk1("rd_ack", 1'b1, a);
        for (int i = 0; i < n; i++)
        begin
            u_host.rd_byte(1'(i == n - 1), d);
            chk24("rd_data", {16'h0000, mem[4'(p + 16'(i))]}, {16'h0000, d});
        end
        u_host.stop();
        chk24("ptr_end", {8'h00, p + 16'(n)}, {8'h00, rd_addr});
        chk1("busy", 1'b0, busy);
        chk24("rd_strobe", 24'(n), 24'(stb_cnt));
    endtask

    ////////////////////////////////////////////////////////////
    // One pass per address pair; second pass fills the buffer
    initial
    begin
        logic        a;
        logic [7:0]  wa, ow;
        logic [15:0] p;
        srst = 1'b1;
        alt  = 1'b0;
        hold = 1'b1;
        wr_ready = 1'b0;
        void'($urandom(12));
        foreach (mem[i])
            mem[i] = 8'($urandom);
        for (int k = 0; k < 2; k++)
        begin
            do_reset(k[0]);
            wa = k[0] ? tci_pkg::ADDR_WR_B : tci_pkg::ADDR_WR_A;
            ow = k[0] ? tci_pkg::ADDR_WR_A : tci_pkg::ADDR_WR_B;
            for (int j = 0; j < 2; j++)
            begin
                u_host.start();
                u_host.wr_byte(ow | 8'(j), a);
                chk1("bad_ack", 1'b0, a);
                u_host.stop();
            end
            p    = k[0] ? 16'hfffe : 16'($urandom);
            hold = k[0];
            wr_burst(wa, p, 10, k[0] ? 8 : 10, 1'b1);
            hold = 1'b0;
            repeat (100) @(negedge clk);
            chk1("drained", 1'b0, wr_valid);
            rd_burst(wa, p, 4);
        end
        final_report();
    end
endmodule // touch_ctrl_i2c_target_port_tb_top
